// file: core/peo_cfg.svh
// Register map, field layout, reset values and timing for the program event outputs.
// Assumes a 40 MHz system clock and a 32-bit Avalon-MM register bus.
`ifndef PEO_CFG_SVH
`define PEO_CFG_SVH
// ==========================================
// Offsets
`define PEO_OFF_CTRL     6'h00
`define PEO_OFF_TS_BASE  6'h04
`define PEO_OFF_TS_STEP  6'h0c
`define PEO_OFF_END_PW   6'h1c
`define PEO_OFF_OUT_SRC  6'h20
`define PEO_OFF_STATUS   6'h24
// ==========================================
// Fields
`define PEO_CTRL_UNIT    0
`define PEO_CTRL_MODE_LO 1
`define PEO_CTRL_SWRST   3
`define PEO_PW_CONT      7
`define PEO_SRC_W        3
// ==========================================
// Reset values
`define PEO_RST_CTRL     3'h0
`define PEO_RST_SEG      6'h00
`define PEO_RST_DELAY    16'h0000
`define PEO_RST_PW       8'h00
`define PEO_RST_SRC      18'h00000
// ==========================================
// Timing
`define PEO_CLK_HZ       40000000
`define PEO_TENTH_MS     100
`define PEO_TENTH_CYC    (`PEO_CLK_HZ / 1000 * `PEO_TENTH_MS)
`define PEO_TENTHS_PER_S 4'd10
`define PEO_S_PER_MIN    6'd60
`endif

// file: core/peo_pkg.sv
// Types shared by the program event outputs block.
// Assumes peo_cfg.svh supplies the register constants; the enum encodings are defined here.
package peo_pkg;
  // ==========================================
  // Output sources
  typedef enum logic [2:0] {
    PEO_SRC_NONE = 3'h0,
    PEO_SRC_TS1  = 3'h1,
    PEO_SRC_TS2  = 3'h2,
    PEO_SRC_END  = 3'h3,
    PEO_SRC_RUN  = 3'h4
  } peo_src_e;
  // ==========================================
  // Operation end modes
  typedef enum logic [1:0] {
    PEO_END_RESET = 2'h0,
    PEO_END_FIXED = 2'h1,
    PEO_END_CONT  = 2'h2
  } peo_end_mode_e;
endpackage

// file: core/peo_program_event_outputs.sv
// Time signals, program end output, run output and output routing.
// Assumes sequencer status inputs come from logic on sys_clk.
// Function
// RQ1: Time signal on after on-delay, off after off-delay, both from segment start.
// RQ2: Two independent time signal channels, each with segment and delays.
// RQ3: Each channel holds a start segment setting, reset value zero.
// RQ4: Delays range 0.00 to 99.59, default 0.00, hours.minutes or minutes.seconds.
// RQ5: Off-delay shorter than on-delay keeps output on until forced off.
// RQ6: Advance before on-delay: output on from next segment start until off-delay.
// RQ7: Time signals off in reset, on intermediate execution end, on fixed-SP end.
// RQ8: Equal on and off delays never turn the output on.
// RQ9: Timers freeze during hold, wait or autotuning and then resume.
// RQ10: Six outputs each select time signal 1, 2, end or run.
// RQ11: End output goes on at last segment end, off after pulse width.
// RQ12: End output only after the final execution of repeats or links.
// RQ13: Pulse width 0.0 to 10.0 s, default 0.0; 0.0 none; continuous option.
// RQ14: Continuous end output stays on until run is selected.
// RQ15: End output clears on run, or on program mode return after fixed-SP end.
// RQ16: End output clears on software reset or entry to control-stopped level.
// RQ17: With reset end mode, leaving configuration level clears end output.
// RQ18: After program end the display alternates with end indication every second.
// RQ19: Run output on in run status, off in reset status.
// RQ20: Delays count on a one second or one minute timebase tick.
`include "peo_cfg.svh"

module peo_program_event_outputs #(
  parameter int unsigned TENTH_CYCLES = `PEO_TENTH_CYC,
  parameter int unsigned SEG_W        = 6
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic [5:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  input  wire logic             seq_run,
  input  wire logic [SEG_W-1:0] seq_segment,
  input  wire logic             seq_seg_start,
  input  wire logic             seq_advance,
  input  wire logic             seq_hold,
  input  wire logic             seq_wait,
  input  wire logic             seq_autotune,
  input  wire logic             seq_exec_done,
  input  wire logic             seq_prog_end,
  input  wire logic             seq_prog_sp_mode,
  input  wire logic             lvl_ctrl_stop,
  input  wire logic             lvl_cfg_exit,
  output logic      [3:0]       aux_out,
  output logic      [1:0]       ctrl_out,
  output logic                  disp_end_ind
);

  // ==========================================
  // Helpers
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  // Four BCD digits tt.uu to ticks of the smaller unit
  function automatic logic [12:0] bcd_ticks(input logic [15:0] v);
    logic [12:0] hi;
    logic [12:0] lo;
    hi = 13'(v[15:12]) * 13'd10 + 13'(v[11:8]);
    lo = 13'(v[7:4]) * 13'd10 + 13'(v[3:0]);
    return hi * 13'd60 + lo;
  endfunction

  function automatic logic pick_src(input logic [2:0] s, input logic [3:0] srcs);
    case (s)
      peo_pkg::PEO_SRC_TS1: return srcs[0];
      peo_pkg::PEO_SRC_TS2: return srcs[1];
      peo_pkg::PEO_SRC_END: return srcs[2];
      peo_pkg::PEO_SRC_RUN: return srcs[3];
      default:              return 1'b0;
    endcase
  endfunction

  // ==========================================
  // Registers
  logic [2:0]       ctrl_q;
  logic [SEG_W-1:0] ts_seg_q [2];
  logic [15:0]      ts_on_q  [2];
  logic [15:0]      ts_off_q [2];
  logic [7:0]       pw_q;
  logic [17:0]      src_q;
  logic             sw_rst_q;
  logic             wait_q;
  logic [31:0]      rdata_q;
  logic [1:0]       ts_q;
  logic             end_q;
  logic             run_q;
  logic             ended_q;
  logic [5:0]       out_q;
  logic             disp_q;

  logic             req;
  logic             wr_go;
  logic             unit_sec;
  peo_pkg::peo_end_mode_e end_mode;

  assign req      = avs_read | avs_write;
  assign wr_go    = avs_write & ~wait_q;
  assign unit_sec = ctrl_q[`PEO_CTRL_UNIT];
  assign end_mode = peo_pkg::peo_end_mode_e'(ctrl_q[`PEO_CTRL_MODE_LO +: 2]);

  // ==========================================
  // Bus handshake: one wait cycle per access
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wait_q <= 1'b1;
    end else if (req && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdata_q <= 32'h0;
    end else if (avs_read && wait_q) begin
      unique case (avs_address)
        `PEO_OFF_CTRL:    rdata_q <= {29'h0, ctrl_q};
        `PEO_OFF_TS_BASE: rdata_q <= 32'(ts_seg_q[0]);
        6'h08:            rdata_q <= {16'h0, ts_on_q[0]};
        6'h0c:            rdata_q <= {16'h0, ts_off_q[0]};
        6'h10:            rdata_q <= 32'(ts_seg_q[1]);
        6'h14:            rdata_q <= {16'h0, ts_on_q[1]};
        6'h18:            rdata_q <= {16'h0, ts_off_q[1]};
        `PEO_OFF_END_PW:  rdata_q <= {24'h0, pw_q};
        `PEO_OFF_OUT_SRC: rdata_q <= {14'h0, src_q};
        `PEO_OFF_STATUS:  rdata_q <= {20'h0, out_q, 1'b0, disp_q, run_q, end_q, ts_q};
        default:          rdata_q <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_q   <= `PEO_RST_CTRL;
      pw_q     <= `PEO_RST_PW;
      src_q    <= `PEO_RST_SRC;
      sw_rst_q <= 1'b0;
    end else begin
      sw_rst_q <= 1'b0;
      if (wr_go && avs_address == `PEO_OFF_CTRL) begin
        ctrl_q   <= 3'(merge_be({29'h0, ctrl_q}, avs_writedata, avs_byteenable));
        sw_rst_q <= avs_byteenable[0] & avs_writedata[`PEO_CTRL_SWRST];
      end
      if (wr_go && avs_address == `PEO_OFF_END_PW) begin
        pw_q <= 8'(merge_be({24'h0, pw_q}, avs_writedata, avs_byteenable)); // RQ13
      end
      if (wr_go && avs_address == `PEO_OFF_OUT_SRC) begin
        src_q <= 18'(merge_be({14'h0, src_q}, avs_writedata, avs_byteenable)); // RQ10
      end
    end
  end

  // ==========================================
  // Timebase
  logic [31:0] pre_q;
  logic [3:0]  tenth_cnt_q;
  logic [5:0]  sec_cnt_q;
  logic        tenth_tick;
  logic        sec_tick;
  logic        min_tick;
  logic        delay_tick;

  assign tenth_tick = (pre_q == 32'(TENTH_CYCLES - 1));
  assign sec_tick   = tenth_tick && (tenth_cnt_q == `PEO_TENTHS_PER_S - 4'd1);
  assign min_tick   = sec_tick && (sec_cnt_q == `PEO_S_PER_MIN - 6'd1);
  assign delay_tick = unit_sec ? sec_tick : min_tick; // RQ20

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pre_q       <= 32'h0;
      tenth_cnt_q <= 4'h0;
      sec_cnt_q   <= 6'h00;
    end else begin
      pre_q <= tenth_tick ? 32'h0 : pre_q + 32'h1;
      if (tenth_tick) begin
        tenth_cnt_q <= sec_tick ? 4'h0 : tenth_cnt_q + 4'h1;
      end
      if (sec_tick) begin
        sec_cnt_q <= min_tick ? 6'h00 : sec_cnt_q + 6'h01;
      end
    end
  end

  // ==========================================
  // Time signal channels
  logic ts_kill;
  logic frozen;

  assign ts_kill = !seq_run || seq_exec_done || sw_rst_q ||
                   (seq_prog_end && end_mode == peo_pkg::PEO_END_FIXED); // RQ7
  assign frozen  = seq_hold | seq_wait | seq_autotune; // RQ9

  genvar gc;
  generate
    for (gc = 0; gc < 2; gc++) begin : g_ts // RQ2
      logic [12:0] elapsed_q;
      logic        running_q;
      logic        gate_q;
      logic        latch_q;
      logic [12:0] on_t;
      logic [12:0] off_t;
      logic        on_hit;
      logic        off_hit;
      logic        wr_seg;
      logic        wr_on;
      logic        wr_off;

      assign on_t    = bcd_ticks(ts_on_q[gc]); // RQ4
      assign off_t   = bcd_ticks(ts_off_q[gc]);
      assign on_hit  = elapsed_q >= on_t;
      assign off_hit = elapsed_q >= off_t;
      assign wr_seg  = wr_go && avs_address == 6'(`PEO_OFF_TS_BASE + gc * `PEO_OFF_TS_STEP);
      assign wr_on   = wr_go && avs_address == 6'(`PEO_OFF_TS_BASE + gc * `PEO_OFF_TS_STEP + 4);
      assign wr_off  = wr_go && avs_address == 6'(`PEO_OFF_TS_BASE + gc * `PEO_OFF_TS_STEP + 8);

      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          ts_seg_q[gc] <= `PEO_RST_SEG; // RQ3
          ts_on_q[gc]  <= `PEO_RST_DELAY; // RQ4
          ts_off_q[gc] <= `PEO_RST_DELAY;
        end else begin
          if (wr_seg) begin
            ts_seg_q[gc] <= SEG_W'(merge_be(32'(ts_seg_q[gc]), avs_writedata, avs_byteenable));
          end
          if (wr_on) begin
            ts_on_q[gc] <= 16'(merge_be({16'h0, ts_on_q[gc]}, avs_writedata, avs_byteenable));
          end
          if (wr_off) begin
            ts_off_q[gc] <= 16'(merge_be({16'h0, ts_off_q[gc]}, avs_writedata, avs_byteenable));
          end
        end
      end

      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          elapsed_q <= 13'h0;
          running_q <= 1'b0;
          gate_q    <= 1'b0;
          latch_q   <= 1'b0;
        end else if (ts_kill) begin
          elapsed_q <= 13'h0; // RQ7
          running_q <= 1'b0;
          gate_q    <= 1'b0;
          latch_q   <= 1'b0;
        end else if (seq_advance && running_q && !on_hit) begin
          elapsed_q <= on_t; // RQ6
          gate_q    <= 1'b1;
        end else if (seq_seg_start && gate_q) begin
          gate_q <= 1'b0; // RQ6
        end else if (seq_seg_start && seq_segment == ts_seg_q[gc] && !latch_q) begin
          elapsed_q <= 13'h0; // RQ1
          running_q <= 1'b1;
        end else begin
          if (running_q && delay_tick && !frozen && elapsed_q != 13'h1fff) begin
            elapsed_q <= elapsed_q + 13'h1; // RQ9
          end
          if (running_q && on_hit && off_t < on_t) begin
            latch_q <= 1'b1; // RQ5
          end
        end
      end

      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          ts_q[gc] <= 1'b0;
        end else if (on_t == off_t || ts_kill) begin
          ts_q[gc] <= 1'b0; // RQ8
        end else begin
          ts_q[gc] <= latch_q || (running_q && !gate_q && on_hit && !off_hit); // RQ1
        end
      end
    end
  endgenerate

  // ==========================================
  // Program end output
  logic [6:0] pw_cnt_q;
  logic       cont_q;
  logic       run_prev_q;
  logic       spm_prev_q;
  logic       run_rise;
  logic       spm_rise;
  logic       end_clr;

  assign run_rise = seq_run && !run_prev_q;
  assign spm_rise = seq_prog_sp_mode && !spm_prev_q;
  assign end_clr  = run_rise || sw_rst_q || lvl_ctrl_stop || // RQ16
                    (spm_rise && ended_q && end_mode == peo_pkg::PEO_END_FIXED) || // RQ15
                    (lvl_cfg_exit && end_mode == peo_pkg::PEO_END_RESET); // RQ17

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      run_prev_q <= 1'b0;
      spm_prev_q <= 1'b0;
    end else begin
      run_prev_q <= seq_run;
      spm_prev_q <= seq_prog_sp_mode;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      end_q    <= 1'b0;
      cont_q   <= 1'b0;
      pw_cnt_q <= 7'h0;
    end else if (seq_prog_end) begin
      cont_q   <= pw_q[`PEO_PW_CONT]; // RQ14
      pw_cnt_q <= pw_q[6:0];
      end_q    <= pw_q[`PEO_PW_CONT] || pw_q[6:0] != 7'h0; // RQ11 RQ12 RQ13
    end else if (end_clr) begin
      end_q    <= 1'b0; // RQ15
      cont_q   <= 1'b0;
      pw_cnt_q <= 7'h0;
    end else if (end_q && !cont_q && tenth_tick) begin
      pw_cnt_q <= pw_cnt_q - 7'h1; // RQ11
      end_q    <= pw_cnt_q != 7'h1;
    end
  end

  // ==========================================
  // End display alternation
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ended_q <= 1'b0;
      disp_q  <= 1'b0;
    end else if (seq_prog_end) begin
      ended_q <= 1'b1; // RQ18
      disp_q  <= 1'b1;
    end else if (run_rise || sw_rst_q) begin
      ended_q <= 1'b0;
      disp_q  <= 1'b0;
    end else if (ended_q && sec_tick) begin
      disp_q <= !disp_q; // RQ18
    end
  end

  // ==========================================
  // Run output and routing
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      run_q <= 1'b0;
    end else begin
      run_q <= seq_run; // RQ19
    end
  end

  genvar go;
  generate
    for (go = 0; go < 6; go++) begin : g_out
      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          out_q[go] <= 1'b0;
        end else begin
          out_q[go] <= pick_src(src_q[go*3 +: 3], {run_q, end_q, ts_q}); // RQ10
        end
      end
    end
  endgenerate

  assign aux_out         = out_q[3:0];
  assign ctrl_out        = out_q[5:4];
  assign disp_end_ind    = disp_q;
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

endmodule

// file: tb/peo_assertions.sv
// Checker for the program event outputs: bus handshake and routed outputs.
// Assumes full byte lanes on writes to the output source register.
module peo_checker (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic        seq_run,
  input wire logic        seq_exec_done,
  input wire logic        seq_prog_end,
  input wire logic        lvl_ctrl_stop,
  input wire logic [3:0]  aux_out,
  input wire logic [1:0]  ctrl_out,
  input wire logic        disp_end_ind
);
  logic [17:0] src_q;

  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // ==========================================
  // Output source shadow
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      src_q <= 18'h0;
    end else if (avs_write && !avs_waitrequest && avs_address == 6'h20
                 && avs_byteenable == 4'hf) begin
      src_q <= avs_writedata[17:0];
    end
  end

  // ==========================================
  // Properties
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest not low one cycle after request");
  a_wait_back: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_idle_wait: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low without request");
  a_run_on: assert property ((seq_run && src_q[2:0] == 3'h4) [*3] |-> aux_out[0])
    else $error("run output not on in run status");
  a_run_off: assert property ((!seq_run && src_q[14:12] == 3'h4) [*3] |-> !ctrl_out[0])
    else $error("run output on in reset status");
  a_none_off: assert property ((src_q[17:15] == 3'h0) [*3] |-> !ctrl_out[1])
    else $error("unassigned output driven");
  a_ts_kill: assert property (seq_exec_done && src_q[5:3] == 3'h1 |-> ##2 !aux_out[1])
    else $error("time signal not off after execution end");
  a_end_stop: assert property (lvl_ctrl_stop && !seq_prog_end && src_q[11:9] == 3'h3
                               |-> ##2 !aux_out[3])
    else $error("end output not cleared on control stop");
  a_end_run: assert property ($rose(seq_run) && !seq_prog_end && src_q[11:9] == 3'h3
                              |-> ##2 !aux_out[3])
    else $error("end output not cleared on run");
  a_end_cause: assert property ($rose(aux_out[3]) && src_q == $past(src_q, 2)
                                |-> $past(seq_prog_end) || $past(seq_prog_end, 2))
    else $error("end output rose without program end");
  a_disp_end: assert property (seq_prog_end |-> ##[1:45] disp_end_ind)
    else $error("end indication not shown after program end");
endmodule

bind peo_program_event_outputs peo_checker chk (
  .sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .seq_run(seq_run), .seq_exec_done(seq_exec_done),
  .seq_prog_end(seq_prog_end), .lvl_ctrl_stop(lvl_ctrl_stop), .aux_out(aux_out),
  .ctrl_out(ctrl_out), .disp_end_ind(disp_end_ind)
);

// file: tb/tb_program_event_outputs.sv
// Self-checking bench for the program event outputs block.
// Assumes the checker file is compiled alongside; register reads do the checking.
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module tb_program_event_outputs;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk = 1'h0;
  logic        resetn = 1'h0;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic        seq_run = 1'h0;
  logic        sp_mode = 1'h0;
  logic [5:0]  avs_address = 6'h0;
  logic [5:0]  seg = 6'h0;
  logic [5:0]  pl = 6'h0;
  logic [2:0]  frz = 3'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  aux_out;
  logic [1:0]  ctrl_out;
  logic        disp_end_ind;
  logic [63:0] expq[$];
  logic [63:0] q;
  int          num_errors = 0;
  int          compares = 0;
  int          seed = 94729;
  int          s;

  always #12.5 sys_clk = ~sys_clk;

  peo_program_event_outputs #(.TENTH_CYCLES(4)) uut (
    .sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .seq_run(seq_run),
    .seq_segment(seg), .seq_seg_start(pl[0]), .seq_advance(pl[1]), .seq_hold(frz[0]),
    .seq_wait(frz[1]), .seq_autotune(frz[2]), .seq_exec_done(pl[2]), .seq_prog_end(pl[3]),
    .seq_prog_sp_mode(sp_mode), .lvl_ctrl_stop(pl[4]), .lvl_cfg_exit(pl[5]),
    .aux_out(aux_out), .ctrl_out(ctrl_out), .disp_end_ind(disp_end_ind)
  );

  // ==========================================
  // Verdict
  task automatic wrap_up();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================
  // Bus and sequencer drivers
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                      input logic [63:0] e);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    if (!w) expq.push_back(e);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest && n < 50);
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (avs_waitrequest) begin
      num_errors++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    xfer(1'h1, a, d, 64'h0);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'h0, a, 32'h0, {m, e});
  endtask

  task automatic st(input logic [31:0] m, input logic [31:0] e);
    rd(6'h24, m, e);
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic p(input int i);
    @(posedge sys_clk);
    pl[i] <= 1'h1;
    @(posedge sys_clk);
    pl[i] <= 1'h0;
  endtask

  // ==========================================
  // Read data monitor
  always @(posedge sys_clk) begin
    if (avs_read && !avs_waitrequest) begin
      q = expq.pop_front();
      `CHK(avs_readdata & q[63:32], q[31:0])
    end
  end

  // ==========================================
  // Scenarios
  initial begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'h1;
    s = $random(seed);
    wr(6'h3c, s);
    for (int i = 0; i < 16; i++) rd(6'(i * 4), 32'hffffffff, 32'h0);
    wr(6'h04, s);
    rd(6'h04, 32'hffffffff, s & 32'h3f);
    wr(6'h00, 32'h1);
    wr(6'h20, 32'h468c);
    rd(6'h20, 32'hffffffff, 32'h468c);
    seq_run <= 1'h1;
    w(3);
    st(32'h448, 32'h448);
    seg <= s[5:0];
    wr(6'h08, 32'h2);
    wr(6'h0c, 32'h4);
    wr(6'h10, s);
    wr(6'h14, 32'h1);
    wr(6'h18, 32'h0);
    p(0);
    w(8);
    st(32'h1, 32'h0);
    w(85);
    st(32'h3, 32'h3);
    w(67);
    st(32'h3, 32'h2);
    p(2);
    w(3);
    st(32'h3, 32'h0);
    wr(6'h14, 32'h3);
    wr(6'h18, 32'h3);
    frz <= 3'h1 << ({$random(seed)} % 3);
    p(0);
    w(150);
    st(32'h3, 32'h0);
    frz <= 3'h0;
    w(95);
    st(32'h3, 32'h1);
    w(67);
    st(32'h3, 32'h0);
    p(0);
    p(1);
    st(32'h1, 32'h0);
    seg <= s[5:0] + 6'h1;
    p(0);
    w(1);
    st(32'h1, 32'h1);
    w(85);
    st(32'h1, 32'h0);
    seq_run <= 1'h0;
    w(3);
    st(32'h448, 32'h0);
    wr(6'h1c, 32'h5);
    p(2);
    w(3);
    st(32'h4, 32'h0);
    p(3);
    w(2);
    st(32'h4, 32'h4);
    w(30);
    st(32'h4, 32'h0);
    wr(6'h1c, 32'h0);
    p(3);
    w(1);
    st(32'h4, 32'h0);
    wr(6'h1c, 32'h80);
    p(3);
    w(100);
    st(32'h4, 32'h4);
    seq_run <= 1'h1;
    w(3);
    st(32'h14, 32'h0);
    seq_run <= 1'h0;
    p(3);
    w(3);
    st(32'h4, 32'h4);
    p(4);
    w(3);
    st(32'h4, 32'h0);
    p(3);
    w(3);
    p(5);
    w(3);
    st(32'h4, 32'h0);
    wr(6'h00, 32'h3);
    p(3);
    w(3);
    st(32'h4, 32'h4);
    sp_mode <= 1'h1;
    w(3);
    st(32'h4, 32'h0);
    p(3);
    w(3);
    wr(6'h00, 32'hb);
    w(2);
    st(32'h14, 32'h0);
    // Minute timebase: on-delay 2 ticks, off-delay one hour
    wr(6'h00, 32'h0);
    wr(6'h0c, 32'h100);
    seg <= s[5:0];
    seq_run <= 1'h1;
    p(0);
    w(200);
    st(32'h1, 32'h0);
    w(4800);
    st(32'h1, 32'h1);
    wrap_up();
  end
endmodule
